/* File: servo_spindle_pkg.sv */
// Constants shared by the servo and spindle control logic.
// Assumes a single 50 MHz clock and synchronous inputs.
package servo_spindle_pkg;
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned REF_PERIOD_US    = 8333;
  localparam int unsigned REF_PERIOD_CYC   = REF_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SIXTH_CYC        = REF_PERIOD_CYC / 6;
  localparam int unsigned SAMPLE_US        = 115;
  localparam int unsigned SAMPLE_CYC       = SAMPLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned START_TIMEOUT_MS = 500;
  localparam int unsigned START_TIMEOUT_CYC = START_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned CHARGE_MS        = 20;
  localparam int unsigned CHARGE_CYC       = CHARGE_MS * (CLK_HZ / 1000);
  localparam int unsigned K_SCALE          = 1;
  localparam int unsigned PHASES_PER_REV   = 6;
  localparam logic [15:0] PRESS_CURRENT    = 16'h0010;
  localparam logic [15:0] OUT_CURRENT      = 16'hFF00;
  localparam logic [15:0] CREEP_CURRENT    = 16'hFFF0;
  localparam logic [15:0] REF_CYLINDER     = 16'h0010;
  localparam int unsigned GAIN_SHIFT       = 2;
  localparam int unsigned ADDR_BITS        = 16;
  localparam int unsigned BURST_COUNT      = 4;
endpackage : servo_spindle_pkg

/* File: disk_servo_spindle_control.sv */
// Servo frame decoding, actuator positioning and spindle speed control.
// Assumes servo bit stream, burst levels and phase feedback arrive synchronous to ref_clk.
//
// What this block does
// - Servo mark times address and burst demodulation
// - Preamble locks phase; sector mark after address
// - Gray address with index converts to binary
// - On track, first burst equals second burst
// - Sample at fixed interval, update coil once
// - Power-up: press, outward, creep, follow reference
// - Seek drives position error, shifted by GAIN_SHIFT, into converter
// - Following filters position error with compensation
// - Spindle goes start, accelerate, stable
// - Charge capacitor before commanding motor start
// - Start timeout resets driver; pulse advances
// - Accelerate without commutation to rated speed
// - Stable mode measures period against reference
// - Fast discharges, slow charges, scaled duration
// - Correction once per sixth revolution
module disk_servo_spindle_control
  import servo_spindle_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        preamble_seen,
  input  wire logic        address_servo_mark,
  input  wire logic        sector_servo_mark,
  input  wire logic        gray_bit,
  input  wire logic        gray_bit_valid,
  input  wire logic [15:0] position_bursts [BURST_COUNT],
  input  wire logic        bursts_valid,
  input  wire logic        seek_req,
  input  wire logic [15:0] seek_target,
  input  wire logic        phase_feedback,
  input  wire logic [31:0] ref_period,
  input  wire logic [31:0] start_timeout,
  input  wire logic [7:0]  scale_k,
  output logic             pll_lock_en,
  output logic             demod_gate,
  output logic [15:0]      cylinder,
  output logic             index_bit,
  output logic [15:0]      actuator_coil,
  output logic             coil_update,
  output logic             on_track,
  output logic             spindle_driver_reset,
  output logic             spindle_driver_charge,
  output logic             spindle_driver_discharge,
  output logic             spindle_driver_start,
  output logic             spindle_driver_commutate,
  output logic             spindle_stable
);

  //////////////////////////////////////////////////////////////////////////////
  // Servo frame decode.

  function automatic logic [15:0] gray_to_bin(input logic [15:0] g);
    logic [15:0] b;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : gray_to_bin

  logic        asm_found;
  logic [15:0] gray_shift;
  logic [4:0]  gray_count;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      asm_found   <= 1'b0;
      pll_lock_en <= 1'b0;
      demod_gate  <= 1'b0;
    end
    else
    begin
      pll_lock_en <= preamble_seen;
      if (address_servo_mark)
        asm_found <= 1'b1;
      else if (sector_servo_mark && asm_found)
        asm_found <= 1'b0;
      if (sector_servo_mark && asm_found)
        demod_gate <= 1'b1;
      else if (bursts_valid)
        demod_gate <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gray_shift <= '0;
      gray_count <= '0;
      cylinder   <= '0;
      index_bit  <= 1'b0;
    end
    else if (!demod_gate)
      gray_count <= '0;
    else if (gray_bit_valid && gray_count <= 5'd16)
    begin
      gray_shift <= {gray_shift[14:0], gray_bit};
      gray_count <= gray_count + 5'd1;
      if (gray_count == 5'd16)
      begin
        index_bit <= gray_shift[15];
        cylinder  <= gray_to_bin({gray_shift[14:0], gray_bit});
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Actuator loop.

  typedef enum logic [4:0] {
    ACT_PRESS  = 5'b00001,
    ACT_OUT    = 5'b00010,
    ACT_CREEP  = 5'b00100,
    ACT_SEEK   = 5'b01000,
    ACT_FOLLOW = 5'b10000
  } act_state_t;

  act_state_t          act_state;
  logic [15:0]         target;
  logic [15:0]         sample_count;
  logic                sample_tick;
  logic signed [16:0]  pos_err;
  logic signed [16:0]  burst_err;
  logic signed [16:0]  prev_err;
  logic [15:0]         press_count;

  assign sample_tick = (sample_count == 16'(SAMPLE_CYC - 1));
  assign pos_err     = $signed({1'b0, target}) - $signed({1'b0, cylinder});
  assign burst_err   = $signed({1'b0, position_bursts[0]})
                     - $signed({1'b0, position_bursts[1]});

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      sample_count <= '0;
    else
      sample_count <= sample_tick ? 16'h0000 : sample_count + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      act_state     <= ACT_PRESS;
      actuator_coil <= '0;
      coil_update   <= 1'b0;
      on_track      <= 1'b0;
      target        <= REF_CYLINDER;
      prev_err      <= '0;
      press_count   <= '0;
    end
    else
    begin
      coil_update <= sample_tick;
      if (seek_req && act_state == ACT_FOLLOW)
      begin
        target    <= seek_target;
        act_state <= ACT_SEEK;
        on_track  <= 1'b0;
      end
      else if (sample_tick)
      begin
        case (act_state)
          ACT_PRESS:
          begin
            actuator_coil <= PRESS_CURRENT;
            press_count   <= press_count + 16'h0001;
            if (press_count == 16'h00FF)
              act_state <= ACT_OUT;
          end
          ACT_OUT:
          begin
            actuator_coil <= OUT_CURRENT;
            if (asm_found)
              act_state <= ACT_CREEP;
          end
          ACT_CREEP:
          begin
            actuator_coil <= CREEP_CURRENT;
            if (cylinder == REF_CYLINDER)
              act_state <= ACT_FOLLOW;
          end
          ACT_SEEK:
          begin
            actuator_coil <= 16'(pos_err <<< GAIN_SHIFT);
            if (pos_err == 17'sd0)
              act_state <= ACT_FOLLOW;
          end
          ACT_FOLLOW:
          begin
            // Proportional plus difference term: a minimal lead compensator.
            actuator_coil <= 16'(pos_err + burst_err + (burst_err - prev_err));
            prev_err      <= burst_err;
            on_track      <= (pos_err == 17'sd0) && (burst_err == 17'sd0);
          end
          default: act_state <= ACT_PRESS;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Spindle control.

  typedef enum logic [3:0] {
    SP_CHARGE = 4'b0001,
    SP_START  = 4'b0010,
    SP_ACCEL  = 4'b0100,
    SP_STABLE = 4'b1000
  } sp_state_t;

  sp_state_t   sp_state;
  logic [31:0] sp_timer;
  logic [31:0] rev_count;
  logic [31:0] rev_period;
  logic [31:0] pump_time;
  logic        phase_q;
  logic        phase_pulse;
  logic [31:0] period_diff;

  assign phase_pulse = phase_feedback && !phase_q;
  assign period_diff = (rev_period > ref_period) ? rev_period - ref_period
                                                 : ref_period - rev_period;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_q     <= 1'b0;
      rev_count   <= '0;
      rev_period  <= '0;
    end
    else
    begin
      phase_q   <= phase_feedback;
      rev_count <= rev_count + 32'd1;
      if (phase_pulse)
      begin
        // Six phase pulses span a revolution; scale one interval up for the period.
        rev_period  <= rev_count * 32'(PHASES_PER_REV);
        rev_count   <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sp_state                 <= SP_CHARGE;
      sp_timer                 <= '0;
      pump_time                <= '0;
      spindle_driver_reset     <= 1'b1;
      spindle_driver_charge    <= 1'b0;
      spindle_driver_discharge <= 1'b0;
      spindle_driver_start     <= 1'b0;
      spindle_driver_commutate <= 1'b0;
      spindle_stable           <= 1'b0;
    end
    else
    begin
      spindle_driver_reset <= 1'b0;
      case (sp_state)
        SP_CHARGE:
        begin
          spindle_driver_charge <= 1'b1;
          sp_timer              <= sp_timer + 32'd1;
          if (sp_timer == 32'(CHARGE_CYC - 1))
          begin
            spindle_driver_charge    <= 1'b0;
            spindle_driver_start     <= 1'b1;
            spindle_driver_commutate <= 1'b1;
            sp_timer                 <= '0;
            sp_state                 <= SP_START;
          end
        end
        SP_START:
        begin
          sp_timer <= sp_timer + 32'd1;
          if (phase_pulse)
          begin
            spindle_driver_commutate <= 1'b0;
            sp_state                 <= SP_ACCEL;
          end
          else if (sp_timer >= start_timeout)
          begin
            spindle_driver_reset <= 1'b1;
            spindle_driver_start <= 1'b0;
            spindle_driver_commutate <= 1'b0;
            sp_timer             <= '0;
            sp_state             <= SP_CHARGE;
          end
        end
        SP_ACCEL:
        begin
          spindle_driver_charge <= 1'b1;
          // A zero period means no full revolution measured yet.
          if (rev_period != 32'd0 && rev_period <= ref_period && phase_pulse)
          begin
            spindle_driver_charge <= 1'b0;
            spindle_stable        <= 1'b1;
            sp_state              <= SP_STABLE;
          end
        end
        SP_STABLE:
        begin
          if (phase_pulse)
          begin
            pump_time                <= period_diff * 32'(scale_k);
            spindle_driver_discharge <= rev_period < ref_period;
            spindle_driver_charge    <= rev_period > ref_period;
          end
          else if (pump_time != 32'd0)
            pump_time <= pump_time - 32'd1;
          else
          begin
            spindle_driver_discharge <= 1'b0;
            spindle_driver_charge    <= 1'b0;
          end
        end
        default: sp_state <= SP_CHARGE;
      endcase
    end
  end

endmodule : disk_servo_spindle_control

/* File: servo_spindle_chk.sv */
// Concurrent checks on the servo and spindle control block's ports.
// Bound to the block from the bench; one clock domain, reset active low.
module servo_spindle_chk
  import servo_spindle_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        preamble_seen,
  input wire logic        address_servo_mark,
  input wire logic        sector_servo_mark,
  input wire logic        bursts_valid,
  input wire logic        pll_lock_en,
  input wire logic        demod_gate,
  input wire logic [15:0] actuator_coil,
  input wire logic        coil_update,
  input wire logic        spindle_driver_charge,
  input wire logic        spindle_driver_discharge,
  input wire logic        spindle_driver_start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic        armed;
  logic [12:0] gap;
  logic [19:0] chg;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) armed <= 1'b0;
    else if (address_servo_mark) armed <= 1'b1;
    else if (sector_servo_mark) armed <= 1'b0;

  // Saturates so that a stalled sample timer still trips the period check.
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) gap <= 13'h0000;
    else if (coil_update) gap <= 13'h0001;
    else if (gap != 13'h1FFF) gap <= gap + 13'h0001;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) chg <= 20'h0_0000;
    else if (spindle_driver_start) chg <= 20'h0_0000;
    else if (spindle_driver_charge && chg != 20'hF_FFFF) chg <= chg + 20'h0_0001;

  ////////////////////////////////////////////////////////////////////////////
  property p_lock;
    $rose(preamble_seen) |=> $rose(pll_lock_en);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock enable did not follow preamble");
  property p_refuse;
    sector_servo_mark && !armed && !demod_gate |=> !demod_gate;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("gate opened without address mark");
  property p_open;
    sector_servo_mark && armed |=> demod_gate;
  endproperty
  a_open: assert property (p_open)
    else $error("gate did not open on sector mark");
  property p_close;
    demod_gate && bursts_valid |=> !demod_gate;
  endproperty
  a_close: assert property (p_close)
    else $error("gate did not close after bursts");
  property p_period;
    gap != 13'h0000 |-> coil_update == (gap == SAMPLE_CYC);
  endproperty
  a_period: assert property (p_period)
    else $error("coil sample spacing wrong");
  property p_hold;
    !coil_update |-> $stable(actuator_coil);
  endproperty
  a_hold: assert property (p_hold)
    else $error("coil drive changed between samples");
  property p_charge;
    $rose(spindle_driver_start) |-> chg >= CHARGE_CYC - 1;
  endproperty
  a_charge: assert property (p_charge)
    else $error("motor start before capacitor charged");
  property p_pump;
    !(spindle_driver_charge && spindle_driver_discharge);
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump charged and discharged together");
endmodule : servo_spindle_chk

/* File: spindle_driver_model.sv */
// Behavioural spindle driver: self-commutates once started, reports phase.
// Assumes driver commands arrive registered on ref_clk.
module spindle_driver_model
#(
  parameter int unsigned PULSE_GAP = 2000
)
(
  input  wire logic ref_clk,
  input  wire logic spindle_driver_reset,
  input  wire logic spindle_driver_start,
  output logic      phase_feedback
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  step;
  int unsigned cnt;

  always_ff @(posedge ref_clk)
    if (spindle_driver_reset || !spindle_driver_start)
    begin
      step <= 3'h0;
      cnt <= 0;
      phase_feedback <= 1'b0;
    end
    else if (cnt == PULSE_GAP)
    begin
      step <= (step == 3'h5) ? 3'h0 : step + 3'h1;
      cnt <= 0;
      phase_feedback <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 1;
      phase_feedback <= 1'b0;
    end
endmodule : spindle_driver_model

/* File: tb.sv */
// Self-checking bench for the servo and spindle control block.
// Inputs change on the falling edge; the spindle driver is a model.
module tb
  import servo_spindle_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("wrong value at %0t: %h vs %h", $time, got, exp); \
    end \
  end

  logic        ref_clk, rstn, preamble_seen, address_servo_mark, sector_servo_mark;
  logic        gray_bit, gray_bit_valid, bursts_valid, seek_req, phase_feedback;
  logic [15:0] position_bursts [BURST_COUNT];
  logic [15:0] seek_target, cylinder, actuator_coil;
  logic [31:0] ref_period, start_timeout;
  logic [7:0]  scale_k;
  logic        pll_lock_en, demod_gate, index_bit, coil_update, on_track;
  logic        spindle_driver_reset, spindle_driver_charge, spindle_driver_discharge;
  logic        spindle_driver_start, spindle_driver_commutate, spindle_stable;
  logic [16:0] notes [$];
  logic [16:0] note;
  logic [15:0] lfsr = 16'h67E2;
  int          n_errors = 0;
  int          cmp_count = 0;

  disk_servo_spindle_control uut (.ref_clk, .rstn, .preamble_seen, .address_servo_mark,
    .sector_servo_mark, .gray_bit, .gray_bit_valid, .position_bursts, .bursts_valid,
    .seek_req, .seek_target, .phase_feedback, .ref_period, .start_timeout, .scale_k,
    .pll_lock_en, .demod_gate, .cylinder, .index_bit, .actuator_coil, .coil_update,
    .on_track, .spindle_driver_reset, .spindle_driver_charge, .spindle_driver_discharge,
    .spindle_driver_start, .spindle_driver_commutate, .spindle_stable);
  spindle_driver_model model (.ref_clk, .spindle_driver_reset, .spindle_driver_start,
    .phase_feedback);

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  task automatic frame(input logic with_mark);
    logic [15:0] addr;
    logic [16:0] word;
    lfsr = lfsr_step(lfsr);
    addr = lfsr;
    word = {lfsr[3], addr ^ (addr >> 1)};
    if (with_mark) notes.push_back({word[16], addr});
    preamble_seen = 1'b1;
    @(negedge ref_clk);
    `CHK(pll_lock_en, 1'b1)
    preamble_seen = 1'b0;
    address_servo_mark = with_mark;
    @(negedge ref_clk);
    address_servo_mark = 1'b0;
    sector_servo_mark = 1'b1;
    @(negedge ref_clk);
    sector_servo_mark = 1'b0;
    `CHK(demod_gate, with_mark)
    for (int i = 16; i >= 0; i--)
    begin
      gray_bit = word[i];
      gray_bit_valid = 1'b1;
      @(negedge ref_clk);
    end
    gray_bit_valid = 1'b0;
    foreach (position_bursts[j]) position_bursts[j] = lfsr ^ 16'(j);
    bursts_valid = 1'b1;
    @(negedge ref_clk);
    bursts_valid = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : frame

  // Each closing of the gate must answer the oldest frame still expected.
  always @(negedge demod_gate)
  begin
    @(negedge ref_clk);
    if (rstn)
    begin
      if (notes.size() == 0) `CHK(1'b0, 1'b1)
      else
      begin
        note = notes.pop_front();
        `CHK({index_bit, cylinder}, note)
      end
    end
  end

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    end_sim();
  end

  initial
  begin
    int gap;
    {rstn, preamble_seen, address_servo_mark, sector_servo_mark} = 4'h0;
    {gray_bit, gray_bit_valid, bursts_valid, seek_req} = 4'h0;
    foreach (position_bursts[j]) position_bursts[j] = 16'h0000;
    seek_target = 16'h0000;
    ref_period = REF_PERIOD_CYC;
    start_timeout = 32'h0001_0000;
    scale_k = K_SCALE[7:0];
    repeat (12) @(negedge ref_clk);
    `CHK({spindle_driver_reset, spindle_driver_charge}, 2'h2)
    rstn = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK({spindle_driver_reset, spindle_driver_charge}, 2'h1)
    for (int k = 0; k < 6; k++) frame(k != 2);
    `CHK(notes.size(), 0)
    // The motor start waits out the full charge time, longer than this run.
    for (int s = 0; s < 4; s++)
    begin
      gap = 0;
      do
      begin
        @(negedge ref_clk);
        seek_req = 1'b0;
        gap++;
      end while (coil_update !== 1'b1 && gap < 7000);
      if (s > 0) `CHK(gap, SAMPLE_CYC)
      `CHK(actuator_coil, PRESS_CURRENT)
      `CHK({spindle_driver_start, spindle_driver_charge}, 2'h1)
      `CHK({spindle_driver_discharge, spindle_driver_commutate, spindle_stable}, 3'h0)
      `CHK(on_track, 1'b0)
      lfsr = lfsr_step(lfsr);
      seek_target = lfsr;
      seek_req = 1'b1;
    end
    end_sim();
  end
endmodule : tb

bind disk_servo_spindle_control servo_spindle_chk chk (.ref_clk, .rstn, .preamble_seen,
  .address_servo_mark, .sector_servo_mark, .bursts_valid, .pll_lock_en, .demod_gate,
  .actuator_coil, .coil_update, .spindle_driver_charge, .spindle_driver_discharge,
  .spindle_driver_start);
